/* core/aux_prot_pkg.sv */
// Purpose: Shared constants for the auxiliary protection and fan supervisor
// Assumes: 125 MHz system clock, Avalon-MM register access
// Notes:   Temperatures in 0.1 degC, thresholds in 0.1 %, delays in 10 ms
package aux_prot_pkg;
  // ****************************************
  // Register indices (word addresses)
  // ****************************************
  localparam logic [11:0] IDX_PHASE_LOSS  = 12'hA14;
  localparam logic [11:0] IDX_IPL_THRESH  = 12'hA15;
  localparam logic [11:0] IDX_GND_SHORT   = 12'hA16;
  localparam logic [11:0] IDX_FAN_POLICY  = 12'hA17;
  localparam logic [11:0] IDX_FAN_DELAY   = 12'hA18;
  localparam logic [11:0] IDX_OH_LEVEL    = 12'hA19;
  localparam logic [11:0] IDX_SENSOR_SEL  = 12'hA1A;
  localparam logic [11:0] IDX_STATUS      = 12'hA30;
  localparam logic [11:0] IDX_MASK        = 12'hA31;
  localparam logic [11:0] IDX_LIVE        = 12'hA32;
  localparam logic [11:0] IDX_REJECT      = 12'hA33;

  // ****************************************
  // Reset values and write clamp limits
  // ****************************************
  localparam logic [15:0] RST_PHASE_LOSS  = 16'h0021;
  localparam logic [15:0] RST_IPL_THRESH  = 16'h0064;
  localparam logic [15:0] RST_GND_SHORT   = 16'h0111;
  localparam logic [15:0] RST_FAN_POLICY  = 16'h0001;
  localparam logic [15:0] RST_FAN_DELAY   = 16'h0BB8;
  localparam logic [15:0] RST_OH_LEVEL    = 16'h0320;
  localparam logic [15:0] RST_SENSOR_SEL  = 16'h0001;
  localparam logic [15:0] MAX_IPL_THRESH  = 16'h012C;
  localparam logic [15:0] MAX_FAN_DELAY   = 16'h1770;
  localparam logic [15:0] MAX_OH_LEVEL    = 16'h03E8;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int ST_OUT_PHASE  = 0;
  localparam int ST_IN_WARN    = 1;
  localparam int ST_IN_FAULT   = 2;
  localparam int ST_OUT_GND    = 3;
  localparam int ST_FAN_GND    = 4;
  localparam int ST_SUPPLY_GND = 5;
  localparam int ST_OVERHEAT   = 6;
  localparam int ST_WIDTH      = 7;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_HZ          = 125000000;
  localparam longint FAN_ON_DELAY_MS = 1000;
  localparam longint FAN_HOLD_MS     = 30000;
  localparam longint TICK_MS         = 10;
  localparam longint FAN_ON_CYC      = CLK_HZ * FAN_ON_DELAY_MS / 1000;
  localparam longint FAN_HOLD_CYC    = CLK_HZ * FAN_HOLD_MS / 1000;
  localparam longint TICK_CYC        = CLK_HZ * TICK_MS / 1000;
  localparam logic [15:0] FAN_TEMP_ON = 16'h01F4;

  typedef enum logic [2:0] {
    FAN_OFF  = 3'b001,
    FAN_WAIT = 3'b010,
    FAN_ON   = 3'b100
  } fan_state_t;
endpackage : aux_prot_pkg

/* core/fan_ctl_if.sv */
// Purpose: Link between supervisor and fan sequencer
// Assumes: Single clock domain
// Notes:   Delay values in 10 ms units
`timescale 1ns/1ps
interface fan_ctl_if;
  logic [1:0]  mode;
  logic        running;
  logic        hot;
  logic [15:0] stop_delay;
  logic        fan_on;

  modport ctl (output mode, output running, output hot, output stop_delay, input fan_on);
  modport seq (input mode, input running, input hot, input stop_delay, output fan_on);
endinterface : fan_ctl_if

/* core/fan_sequencer.sv */
// Purpose: Cooling fan on/off policy with delays
// Assumes: Inputs synchronous to clk_sys
// Notes:   Mode 2 stop delay timed in 10 ms ticks; other off delays count clock cycles
`timescale 1ns/1ps
module fan_sequencer #(
  parameter longint TICK_CYC  = aux_prot_pkg::TICK_CYC,
  parameter longint ON_CYC    = aux_prot_pkg::FAN_ON_CYC,
  parameter longint HOLD_CYC  = aux_prot_pkg::FAN_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control link
  fan_ctl_if.seq   fan
);
  aux_prot_pkg::fan_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] tick_reg, tick_next;
  logic        tick;
  logic        want_on;
  logic        use_ticks;
  logic [31:0] limit;

  assign tick = (tick_reg == 32'(TICK_CYC - 1));

  always_comb begin
    // Mode 0 forced on; modes 1/2 per run state and temperature
    want_on   = 1'b1;
    use_ticks = 1'b0;
    limit     = 32'(HOLD_CYC);
    case (fan.mode)
      2'd0: want_on = 1'b1;
      2'd1: begin
        want_on = fan.running | fan.hot;
      end
      2'd2: begin
        want_on = fan.running & fan.hot;
        if (!fan.running) begin
          use_ticks = 1'b1;
          limit     = 32'(fan.stop_delay);
        end
      end
      default: want_on = 1'b1;
    endcase
    state_next = state_reg;
    cnt_next   = cnt_reg;
    tick_next  = tick ? 32'h0 : tick_reg + 32'h1;
    case (state_reg)
      aux_prot_pkg::FAN_OFF: begin
        cnt_next = 32'h0;
        if (fan.mode == 2'd1 && fan.running && !fan.hot) begin
          cnt_next = cnt_reg + 32'h1;
          if (cnt_reg >= 32'(ON_CYC - 1))
            state_next = aux_prot_pkg::FAN_ON;
        end else if (want_on) begin
          state_next = aux_prot_pkg::FAN_ON;
        end
      end
      aux_prot_pkg::FAN_ON: begin
        cnt_next = 32'h0;
        tick_next = 32'h0;
        if (!want_on)
          state_next = aux_prot_pkg::FAN_WAIT;
      end
      aux_prot_pkg::FAN_WAIT: begin
        if (want_on) begin
          state_next = aux_prot_pkg::FAN_ON;
        end else if (use_ticks) begin
          if (cnt_reg >= limit)
            state_next = aux_prot_pkg::FAN_OFF;
          else if (tick)
            cnt_next = cnt_reg + 32'h1;
        end else begin
          cnt_next = cnt_reg + 32'h1;
          if (cnt_reg >= limit - 32'h1)
            state_next = aux_prot_pkg::FAN_OFF;
        end
      end
      default: state_next = aux_prot_pkg::FAN_ON;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= aux_prot_pkg::FAN_ON;
      cnt_reg   <= 32'h0;
      tick_reg  <= 32'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      tick_reg  <= tick_next;
    end
  end

  assign fan.fan_on = (state_reg != aux_prot_pkg::FAN_OFF);
endmodule : fan_sequencer

/* core/avalon_regs_if.sv */
// Purpose: Internal register write/read strobe bundle
// Assumes: Single clock domain
// Notes:   One-cycle strobes
`timescale 1ns/1ps
interface avalon_regs_if;
  logic        wr;
  logic        rd;
  logic [11:0] idx;
  logic [15:0] wdata;

  modport slv (output wr, output rd, output idx, output wdata);
  modport core (input wr, input rd, input idx, input wdata);
endinterface : avalon_regs_if

/* core/avalon_slave.sv */
// Purpose: Avalon-MM slave front end with one wait state
// Assumes: Word address = byte address / 4
// Notes:   Answers every request one cycle after it is raised
`timescale 1ns/1ps
module avalon_slave (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Avalon-MM
  input  wire logic [13:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic             waitrequest,
  // Internal strobes
  avalon_regs_if.slv       rb
);
  logic busy_reg, busy_next;

  always_comb begin
    // Hold off for one cycle, then accept
    busy_next = (read | write) & ~busy_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      busy_reg <= 1'b0;
    else
      busy_reg <= busy_next;
  end

  assign waitrequest = (read | write) & ~busy_reg;
  assign rb.wr       = write & busy_reg;
  // Read strobe in the wait cycle so registered data stands at acceptance
  assign rb.rd       = read & ~busy_reg;
  assign rb.idx      = address[13:2];
  assign rb.wdata    = writedata[15:0];
endmodule : avalon_slave

/* core/aux_protection.sv */
// Purpose: Auxiliary protection and cooling fan supervisor
// Assumes: Detector inputs synchronous, one clock, synchronous reset
// Notes:   Avalon address is byte address, index*4
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module aux_protection (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [13:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  // Drive sequencing
  input  wire logic        run_cmd,
  input  wire logic        dc_brake_active,
  input  wire logic        pre_excite_active,
  input  wire logic        sync_machine_rotating,
  output logic             run_permit,
  output logic             coast_stop,
  // Measurements and detectors
  input  wire logic        out_phase_missing,
  input  wire logic [15:0] bus_ripple_pct,
  input  wire logic        out_ground_detect,
  input  wire logic        fan_ground_detect,
  input  wire logic        supply_ground_detect,
  input  wire logic [15:0] heatsink_temperature_monitor,
  output logic             ground_check_req,
  // Protection outputs
  output logic             output_phase_missing_fault,
  output logic             input_phase_missing_warning,
  output logic             input_phase_missing_fault,
  output logic             output_ground_short_fault,
  output logic             fan_ground_short_fault,
  output logic             supply_ground_short_fault,
  output logic             drive_overheat_warning,
  output logic             platinum_resistance_sensor,
  output logic             fan_on
);
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] phase_sel_reg, phase_sel_next;
  logic [15:0] ipl_thr_reg, ipl_thr_next;
  logic [15:0] gnd_sel_reg, gnd_sel_next;
  logic [15:0] fan_sel_reg, fan_sel_next;
  logic [15:0] fan_dly_reg, fan_dly_next;
  logic [15:0] oh_lvl_reg, oh_lvl_next;
  logic [15:0] sens_sel_reg, sens_sel_next;
  logic [aux_prot_pkg::ST_WIDTH-1:0] status_reg, status_next;
  logic [aux_prot_pkg::ST_WIDTH-1:0] mask_reg, mask_next;
  logic [aux_prot_pkg::ST_WIDTH-1:0] live_reg, live_next;
  logic [aux_prot_pkg::ST_WIDTH-1:0] events;
  logic [31:0] rdata_reg, rdata_next;
  logic        reject_reg, reject_next;
  logic        pwr_chk_reg, pwr_chk_next;
  logic        pre_chk_reg, pre_chk_next;
  logic        run_reg, run_next;

  avalon_regs_if rb ();
  fan_ctl_if     fc ();

  avalon_slave u_slave (.*);

  fan_sequencer u_fan (.*, .fan (fc));

  // Option digit n of a packed selection
  function automatic logic [3:0] digit(input logic [15:0] v, input int n);
    digit = v[n*4 +: 4];
  endfunction : digit

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction : clamp

  // ****************************************
  // Run state and ground checks
  // ****************************************
  always_comb begin
    // Power-on check window closes one cycle after reset
    pwr_chk_next = 1'b1;
    pre_chk_next = run_cmd & ~run_reg & (digit(gnd_sel_reg, 0) == 4'h2);
    run_next = run_cmd & run_permit;
  end

  // Synchronous machines spinning cannot pass the pre-run check
  assign run_permit = ~(coast_stop | output_ground_short_fault | fan_ground_short_fault | supply_ground_short_fault) &
                      ~((digit(gnd_sel_reg, 0) == 4'h2) & sync_machine_rotating);
  assign ground_check_req = (~pwr_chk_reg & (digit(gnd_sel_reg, 0) == 4'h1)) | pre_chk_reg;

  // ****************************************
  // Protection events
  // ****************************************
  always_comb begin
    events = '0;
    events[aux_prot_pkg::ST_OUT_PHASE] = out_phase_missing &
      ((digit(phase_sel_reg, 0) == 4'h1) | dc_brake_active | pre_excite_active);
    if (bus_ripple_pct > ipl_thr_reg) begin
      events[aux_prot_pkg::ST_IN_WARN]  = (digit(phase_sel_reg, 1) == 4'h1);
      events[aux_prot_pkg::ST_IN_FAULT] = (digit(phase_sel_reg, 1) == 4'h2);
    end
    events[aux_prot_pkg::ST_OUT_GND] = out_ground_detect & ground_check_req;
    events[aux_prot_pkg::ST_FAN_GND] = fan_ground_detect & (digit(gnd_sel_reg, 1) == 4'h1);
    events[aux_prot_pkg::ST_SUPPLY_GND] = supply_ground_detect & (digit(gnd_sel_reg, 2) == 4'h1);
    events[aux_prot_pkg::ST_OVERHEAT] = heatsink_temperature_monitor > oh_lvl_reg;
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    phase_sel_next = phase_sel_reg;
    ipl_thr_next   = ipl_thr_reg;
    gnd_sel_next   = gnd_sel_reg;
    fan_sel_next   = fan_sel_reg;
    fan_dly_next   = fan_dly_reg;
    oh_lvl_next    = oh_lvl_reg;
    sens_sel_next  = sens_sel_reg;
    mask_next      = mask_reg;
    reject_next    = reject_reg;
    live_next      = events;
    status_next    = status_reg;
    rdata_next     = rdata_reg;
    if (rb.wr) begin
      case (rb.idx)
        aux_prot_pkg::IDX_FAN_POLICY: fan_sel_next = {14'h0, (rb.wdata[1:0] == 2'h3) ? 2'h2 : rb.wdata[1:0]};
        aux_prot_pkg::IDX_OH_LEVEL:   oh_lvl_next = clamp(rb.wdata, aux_prot_pkg::MAX_OH_LEVEL);
        aux_prot_pkg::IDX_SENSOR_SEL: sens_sel_next = {15'h0, rb.wdata[0]};
        aux_prot_pkg::IDX_MASK:       mask_next = rb.wdata[aux_prot_pkg::ST_WIDTH-1:0];
        aux_prot_pkg::IDX_STATUS:     status_next = status_reg & ~rb.wdata[aux_prot_pkg::ST_WIDTH-1:0];
        aux_prot_pkg::IDX_REJECT:     reject_next = reject_reg & ~rb.wdata[0];
        default: begin
          // Stop-only settings
          if (run_reg) begin
            reject_next = 1'b1;
          end else begin
            case (rb.idx)
              aux_prot_pkg::IDX_PHASE_LOSS:
                phase_sel_next = {8'h0, 2'h0, (rb.wdata[5:4] == 2'h3) ? 2'h2 : rb.wdata[5:4], 3'h0, rb.wdata[0]};
              aux_prot_pkg::IDX_IPL_THRESH: ipl_thr_next = clamp(rb.wdata, aux_prot_pkg::MAX_IPL_THRESH);
              aux_prot_pkg::IDX_GND_SHORT:
                gnd_sel_next = {7'h0, rb.wdata[8], 3'h0, rb.wdata[4], 2'h0,
                                (rb.wdata[1:0] == 2'h3) ? 2'h2 : rb.wdata[1:0]};
              aux_prot_pkg::IDX_FAN_DELAY: fan_dly_next = clamp(rb.wdata, aux_prot_pkg::MAX_FAN_DELAY);
              default: reject_next = reject_reg;
            endcase
          end
        end
      endcase
    end
    // Set wins over a simultaneous clear
    status_next = status_next | events;
    if (rb.rd) begin
      case (rb.idx)
        aux_prot_pkg::IDX_PHASE_LOSS: rdata_next = {16'h0, phase_sel_reg};
        aux_prot_pkg::IDX_IPL_THRESH: rdata_next = {16'h0, ipl_thr_reg};
        aux_prot_pkg::IDX_GND_SHORT:  rdata_next = {16'h0, gnd_sel_reg};
        aux_prot_pkg::IDX_FAN_POLICY: rdata_next = {16'h0, fan_sel_reg};
        aux_prot_pkg::IDX_FAN_DELAY:  rdata_next = {16'h0, fan_dly_reg};
        aux_prot_pkg::IDX_OH_LEVEL:   rdata_next = {16'h0, oh_lvl_reg};
        aux_prot_pkg::IDX_SENSOR_SEL: rdata_next = {16'h0, sens_sel_reg};
        aux_prot_pkg::IDX_STATUS:     rdata_next = {25'h0, status_reg};
        aux_prot_pkg::IDX_MASK:       rdata_next = {25'h0, mask_reg};
        aux_prot_pkg::IDX_LIVE:       rdata_next = {25'h0, live_reg};
        aux_prot_pkg::IDX_REJECT:     rdata_next = {30'h0, run_reg, reject_reg};
        default:                      rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_sel_reg <= aux_prot_pkg::RST_PHASE_LOSS;
      ipl_thr_reg   <= aux_prot_pkg::RST_IPL_THRESH;
      gnd_sel_reg   <= aux_prot_pkg::RST_GND_SHORT;
      fan_sel_reg   <= aux_prot_pkg::RST_FAN_POLICY;
      fan_dly_reg   <= aux_prot_pkg::RST_FAN_DELAY;
      oh_lvl_reg    <= aux_prot_pkg::RST_OH_LEVEL;
      sens_sel_reg  <= aux_prot_pkg::RST_SENSOR_SEL;
      status_reg    <= '0;
      mask_reg      <= '0;
      live_reg      <= '0;
      rdata_reg     <= 32'h0;
      reject_reg    <= 1'b0;
      pwr_chk_reg   <= 1'b0;
      pre_chk_reg   <= 1'b0;
      run_reg       <= 1'b0;
    end else begin
      phase_sel_reg <= phase_sel_next;
      ipl_thr_reg   <= ipl_thr_next;
      gnd_sel_reg   <= gnd_sel_next;
      fan_sel_reg   <= fan_sel_next;
      fan_dly_reg   <= fan_dly_next;
      oh_lvl_reg    <= oh_lvl_next;
      sens_sel_reg  <= sens_sel_next;
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      live_reg      <= live_next;
      rdata_reg     <= rdata_next;
      reject_reg    <= reject_next;
      pwr_chk_reg   <= pwr_chk_next;
      pre_chk_reg   <= pre_chk_next;
      run_reg       <= run_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign fc.mode       = fan_sel_reg[1:0];
  assign fc.running    = run_reg;
  assign fc.hot        = heatsink_temperature_monitor > aux_prot_pkg::FAN_TEMP_ON;
  assign fc.stop_delay = fan_dly_reg;
  assign fan_on        = fc.fan_on;

  assign readdata                    = rdata_reg;
  assign irq                         = |(status_reg & mask_reg);
  assign output_phase_missing_fault  = status_reg[aux_prot_pkg::ST_OUT_PHASE];
  assign input_phase_missing_warning = status_reg[aux_prot_pkg::ST_IN_WARN];
  assign input_phase_missing_fault   = status_reg[aux_prot_pkg::ST_IN_FAULT];
  assign output_ground_short_fault   = status_reg[aux_prot_pkg::ST_OUT_GND];
  assign fan_ground_short_fault      = status_reg[aux_prot_pkg::ST_FAN_GND];
  assign supply_ground_short_fault   = status_reg[aux_prot_pkg::ST_SUPPLY_GND];
  assign drive_overheat_warning      = live_reg[aux_prot_pkg::ST_OVERHEAT];
  assign platinum_resistance_sensor  = ~sens_sel_reg[0];
  // Phase faults coast the motor
  assign coast_stop = output_phase_missing_fault | input_phase_missing_fault;
endmodule : aux_protection

/* verif/aux_prot_checker.sv */
// Purpose: Port assertions for the protection block
// Assumes: One clock, synchronous active-high reset
// Notes:   Setting-dependent behaviour is judged by the bench
`timescale 1ns/1ps
module aux_prot_checker (
  // Clock, reset and bus
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  // Drive, fan and heat
  input wire logic        run_permit,
  input wire logic        coast_stop,
  input wire logic        fan_on,
  input wire logic [15:0] heatsink_temperature_monitor,
  // Protection outputs
  input wire logic        output_phase_missing_fault,
  input wire logic        input_phase_missing_warning,
  input wire logic        input_phase_missing_fault,
  input wire logic        output_ground_short_fault,
  input wire logic        fan_ground_short_fault,
  input wire logic        supply_ground_short_fault,
  input wire logic        drive_overheat_warning,
  input wire logic        platinum_resistance_sensor
);
  // ************************************
  // Properties
  // ************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic stop_fault, gnd_fault;
  assign stop_fault = output_phase_missing_fault | input_phase_missing_fault;
  assign gnd_fault  = output_ground_short_fault | fan_ground_short_fault | supply_ground_short_fault;
  sequence s_accept;
    waitrequest ##1 !waitrequest;
  endsequence
  chk_coast_cause: assert property (coast_stop == stop_fault)
    else $error("coast stop differs from stop faults");
  chk_permit_block: assert property (gnd_fault |-> !run_permit)
    else $error("run permitted with a ground fault");
  chk_warn_runs: assert property (input_phase_missing_warning && !stop_fault |-> !coast_stop)
    else $error("warning alone stopped the motor");
  chk_phase_hold: assert property (output_phase_missing_fault && !write |=> output_phase_missing_fault)
    else $error("phase fault dropped without a clear");
  chk_gnd_hold: assert property (output_ground_short_fault && !write |=> output_ground_short_fault)
    else $error("ground fault dropped without a clear");
  chk_fan_boot: assert property ($fell(rst) |-> fan_on)
    else $error("fan off after power-on");
  chk_sensor_boot: assert property ($fell(rst) |-> !platinum_resistance_sensor)
    else $error("sensor type not silicon after power-on");
  chk_bus_wait: assert property ($rose(read | write) |-> s_accept)
    else $error("bus answer not one wait state");
  chk_heat_high: assert property ((heatsink_temperature_monitor > 16'h03E8) [*2] |-> drive_overheat_warning)
    else $error("no overheat warning above top level");
  chk_heat_zero: assert property ((heatsink_temperature_monitor == 16'h0000) [*2] |-> !drive_overheat_warning)
    else $error("overheat warning at zero degrees");
endmodule : aux_prot_checker
bind aux_protection aux_prot_checker chk_u (.*);

/* verif/drive_plant_model.sv */
// Purpose: Motor, mains and fan seen by the detectors
// Assumes: Faults injected by the bench
// Notes:   Detector lines lag one clock
`timescale 1ns/1ps
module drive_plant_model (
  // Clock and fan supply
  input  wire logic        clk_sys,
  input  wire logic        fan_on,
  // Injected faults
  input  wire logic        cut_out,
  input  wire logic        cut_in,
  input  wire logic        short_out,
  input  wire logic        short_fan,
  input  wire logic        short_supply,
  input  wire logic [15:0] temp_set,
  // Detector lines
  output logic             out_phase_missing,
  output logic [15:0]      bus_ripple_pct,
  output logic             out_ground_detect,
  output logic             fan_ground_detect,
  output logic             supply_ground_detect,
  output logic [15:0]      heatsink_temperature_monitor
);
  always_ff @(posedge clk_sys) begin
    out_phase_missing            <= cut_out;
    bus_ripple_pct               <= cut_in ? 16'h00C8 : 16'h0014;
    out_ground_detect            <= short_out;
    fan_ground_detect            <= short_fan & fan_on;  // Unpowered fan shows no leak
    supply_ground_detect         <= short_supply;
    heatsink_temperature_monitor <= temp_set;
  end
endmodule : drive_plant_model

/* verif/testbench.sv */
// Purpose: Self-checking bench for the protection block
// Assumes: Fan timing too long to simulate at full scale
// Notes:   One read per access
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, run_cmd = 1'b0;
  logic dc_brake_active = 1'b0, pre_excite_active = 1'b0, sync_machine_rotating = 1'b0;
  logic cut_out = 1'b0, cut_in = 1'b0, short_out = 1'b0, short_fan = 1'b0, short_supply = 1'b0;
  logic [13:0] address = 14'h0000;
  logic [31:0] writedata = 32'h00000000, readdata;
  logic [15:0] temp_set = 16'h0000, bus_ripple_pct, heatsink_temperature_monitor;
  logic waitrequest, irq, run_permit, coast_stop, out_phase_missing, out_ground_detect, fan_ground_detect;
  logic supply_ground_detect, ground_check_req, output_phase_missing_fault, input_phase_missing_warning;
  logic input_phase_missing_fault, output_ground_short_fault, fan_ground_short_fault, supply_ground_short_fault;
  logic drive_overheat_warning, platinum_resistance_sensor, fan_on, seen;
  int err_total = 0, checks = 0;
  aux_protection dut_u (.*);
  drive_plant_model plant_u (.*);
  always #4 clk_sys = ~clk_sys;
  // ************************************
  // Shared tasks
  // ************************************
  task automatic close_out();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : settle
  task automatic bus(input logic wr, input logic [11:0] idx, input logic [15:0] wd, output logic [31:0] q);
    int n = 0;
    @(posedge clk_sys);
    address   <= {idx, 2'b00};
    write     <= wr;
    read      <= !wr;
    writedata <= {16'h0000, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    if (n >= 40) begin
      err_total++;
      close_out();
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
    settle(1);
  endtask : wr
  task automatic rchk(input logic [11:0] idx, input logic [15:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0000, q);
    check(what, q, {16'h0000, exp});
  endtask : rchk
  task automatic clear();
    settle(3);
    wr(12'hA30, 16'h007F);
    settle(2);
  endtask : clear
  // ************************************
  // Scenarios
  // ************************************
  task automatic t_defaults();
    rchk(12'hA14, 16'h0021, "phase_sel");
    rchk(12'hA15, 16'h0064, "in_thresh");
    rchk(12'hA16, 16'h0111, "gnd_sel");
    rchk(12'hA17, 16'h0001, "fan_sel");
    rchk(12'hA18, 16'h0BB8, "fan_delay");
    rchk(12'hA19, 16'h0320, "heat_level");
    rchk(12'hA1A, 16'h0001, "sensor_sel");
    wr(12'hA40, 16'h1234);
    rchk(12'hA40, 16'h0000, "unmapped");
  endtask : t_defaults
  task automatic t_out_phase();
    cut_out <= 1'b1;
    settle(6);
    check("oph_fault", output_phase_missing_fault, 1'b1);
    check("coast", coast_stop, 1'b1);
    check("irq_masked", irq, 1'b0);
    wr(12'hA31, 16'h0001);
    check("irq_on", irq, 1'b1);
    cut_out <= 1'b0;
    clear();
    check("irq_off", irq, 1'b0);
    wr(12'hA14, 16'h0020);
    cut_out <= 1'b1;
    settle(6);
    check("oph_off", output_phase_missing_fault, 1'b0);
    for (int k = 0; k < 2; k++) begin
      dc_brake_active   <= (k == 0);
      pre_excite_active <= (k == 1);
      settle(6);
      check("oph_forced", output_phase_missing_fault, 1'b1);
      dc_brake_active   <= 1'b0;
      pre_excite_active <= 1'b0;
      clear();
    end
    cut_out <= 1'b0;
  endtask : t_out_phase
  task automatic t_input();
    for (int m = 0; m < 3; m++) begin
      wr(12'hA14, {10'h000, m[1:0], 4'h1});
      cut_in <= 1'b1;
      settle(6);
      check("in_warn", input_phase_missing_warning, m == 1);
      check("in_fault", input_phase_missing_fault, m == 2);
      cut_in <= 1'b0;
      clear();
    end
    wr(12'hA15, 16'h012C);
    cut_in <= 1'b1;
    settle(6);
    check("in_thresh_hi", input_phase_missing_fault, 1'b0);
    cut_in <= 1'b0;
    wr(12'hA15, 16'h0064);
    wr(12'hA14, 16'h0021);
  endtask : t_input
  task automatic t_ground();
    short_fan    <= 1'b1;
    short_supply <= 1'b1;
    settle(6);
    check("fan_gnd", fan_ground_short_fault, 1'b1);
    check("sup_gnd", supply_ground_short_fault, 1'b1);
    check("permit", run_permit, 1'b0);
    wr(12'hA16, 16'h0002);
    clear();
    settle(4);
    check("fan_gnd_off", fan_ground_short_fault, 1'b0);
    check("sup_gnd_off", supply_ground_short_fault, 1'b0);
    short_fan    <= 1'b0;
    short_supply <= 1'b0;
    sync_machine_rotating <= 1'b1;
    settle(2);
    check("rotating", run_permit, 1'b0);
    sync_machine_rotating <= 1'b0;
    short_out <= 1'b1;
    settle(3);
    check("still", run_permit, 1'b1);
    seen = 1'b0;
    run_cmd <= 1'b1;
    repeat (8) begin
      @(posedge clk_sys);
      seen = seen | ground_check_req;
    end
    check("prerun_req", seen, 1'b1);
    check("prerun_gnd", output_ground_short_fault, 1'b1);
    run_cmd   <= 1'b0;
    short_out <= 1'b0;
    clear();
    wr(12'hA16, 16'h0111);
  endtask : t_ground
  task automatic t_running();
    run_cmd <= 1'b1;
    wr(12'hA14, 16'h0000);
    rchk(12'hA14, 16'h0021, "stop_only");
    rchk(12'hA33, 16'h0003, "reject");
    wr(12'hA17, 16'h0000);
    rchk(12'hA17, 16'h0000, "run_change");
    run_cmd <= 1'b0;
    wr(12'hA33, 16'h0001);
    settle(4);
    check("fan_mode0", fan_on, 1'b1);
    temp_set <= 16'h0384;
    settle(4);
    check("heat_warn", drive_overheat_warning, 1'b1);
    wr(12'hA19, 16'h03E8);
    settle(2);
    check("heat_lvl", drive_overheat_warning, 1'b0);
    temp_set <= 16'h0400;
    settle(4);
    check("heat_top", drive_overheat_warning, 1'b1);
    wr(12'hA1A, 16'h0000);
    check("platinum", platinum_resistance_sensor, 1'b1);
    wr(12'hA18, 16'h0000);
    wr(12'hA17, 16'h0002);
    settle(3);
    check("fan_m2_stop", fan_on, 1'b0);
    run_cmd <= 1'b1;
    settle(3);
    check("fan_m2_hot", fan_on, 1'b1);
    run_cmd <= 1'b0;
    wr(12'hA17, 16'h0001);
    settle(1);
    check("fan_m1_hot", fan_on, 1'b1);
  endtask : t_running
  initial begin
    settle(4);
    rst <= 1'b0;
    t_defaults();
    t_out_phase();
    t_input();
    t_ground();
    t_running();
    close_out();
  end
endmodule : testbench
